// *** common/mml_pkg.sv ***
`default_nettype none
package mml_pkg;
    // =====================================================
    // clock and link rate
    localparam int CLK_KHZ = 100000;
    localparam int CLK_NS = 10;
    localparam int RATE_MIN_KBPS = 32;
    localparam int RATE_MAX_KBPS = 80;
    localparam int RATE_KBPS = 70;
    localparam int BIT_MIN_NS = 13600;
    localparam int BIT_NOM_NS = 14300;
    localparam int BIT_MAX_NS = 15000;
    localparam int BIT_CYC = CLK_KHZ / RATE_KBPS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int DRIFT_PCT = 11;
    localparam int WIN_OPEN_CYC = HALF_CYC * (100 - 2 * DRIFT_PCT) / 50;
    localparam int WIN_CLOSE_CYC = HALF_CYC * (100 + 2 * DRIFT_PCT) / 50;
    // =====================================================
    // gaps and delays
    localparam int GAP_BITS = 2;
    localparam int GAP_CYC = GAP_BITS * BIT_CYC;
    localparam int SETUP_US = 40;
    localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int RESP_MAX_US = 150;
    localparam int RESP_MAX_CYC = RESP_MAX_US * 1000 / CLK_NS;
    localparam int UNLOCK_MS = 8;
    localparam int UNLOCK_CYC = UNLOCK_MS * 1000 * 1000 / CLK_NS;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * 1000 / CLK_NS;
    localparam int PULSE_GAP_US = 100;
    localparam int PULSE_GAP_CYC = PULSE_GAP_US * 1000 / CLK_NS;
    localparam int CNT_W = 20;
    // =====================================================
    // frame layout
    localparam int ADDR_W = 6;
    localparam int DATA_W = 30;
    localparam int PAY_W = 24;
    localparam int CRC_W = 3;
    localparam int BODY_W = 1 + ADDR_W + DATA_W;
    localparam int FRAME_W = 2 + BODY_W + CRC_W;
    localparam int READ_BITS = 2 + 1 + ADDR_W + CRC_W;
    localparam int READ_BODY = 1 + ADDR_W;
    localparam int ACK_BITS = 2 + DATA_W + CRC_W;
    localparam int ADDR_SEL_BIT = 5;
    localparam int ECC_HI = 25;
    localparam int ECC_LO = 24;
    localparam logic [2:0] CRC_INIT = 3'h7;
    localparam logic [5:0] ACCESS_ADDR = 6'h24;
    localparam logic [29:0] ACCESS_DATA = 30'h27811F77;
    // =====================================================
    // state types
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_TX = 7'h02,
        S_SETUP = 7'h04,
        S_PULSE = 7'h08,
        S_PGAP = 7'h10,
        S_RESP = 7'h20,
        S_GAP = 7'h40
    } mml_state_t;
    typedef enum logic [2:0] {
        R_OFF = 3'h1,
        R_HUNT = 3'h2,
        R_BITS = 3'h4
    } mml_rx_state_t;
    // =====================================================
    // checksum x^3+x+1 over the leading n bits, msb first
    function automatic logic [2:0] crc_msb(input logic [BODY_W-1:0] bits, input int n);
        logic [2:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 0; i < BODY_W; i++) begin
            if (i < n) begin
                fb = c[2] ^ bits[BODY_W-1-i];
                c = {c[1], c[0] ^ fb, fb};
            end
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// *** common/mml_rx_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface mml_rx_if;
    logic en;
    logic line;
    logic locked;
    logic done;
    logic err;
    logic [mml_pkg::ACK_BITS-3:0] bits;
    modport ctrl (output en, output line, input locked, input done, input err, input bits);
    modport rx (input en, input line, output locked, output done, output err, output bits);
endinterface
`default_nettype wire

// *** logic/mml_ack_rx.sv ***
`timescale 1ns/100ps
`default_nettype none
module mml_ack_rx #(
    parameter int WIN_OPEN = mml_pkg::WIN_OPEN_CYC,
    parameter int WIN_CLOSE = mml_pkg::WIN_CLOSE_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // controller side
    mml_rx_if.rx rx
);
    localparam int CW = 16;
    localparam logic [5:0] LAST_BIT = 6'(mml_pkg::ACK_BITS - 1);
    mml_pkg::mml_rx_state_t st_ff;
    logic prev_ff;
    logic [CW-1:0] cnt_ff;
    logic [5:0] nbit_ff;
    logic [mml_pkg::ACK_BITS-3:0] sr_ff;
    logic done_ff;
    logic err_ff;
    // =====================================================
    // edge and window decode
    wire rise_w = rx.line & ~prev_ff;
    wire edge_w = rx.line ^ prev_ff;
    wire win_w = cnt_ff >= CW'(WIN_OPEN); // RL4
    wire late_w = cnt_ff >= CW'(WIN_CLOSE); // RL4
    wire val_w = prev_ff; // RL11
    wire mid_w = (st_ff == mml_pkg::R_BITS) & edge_w & win_w;
    wire sync_bad_w = mid_w & (nbit_ff == 6'h01) & val_w; // RL12
    wire last_w = mid_w & (nbit_ff == LAST_BIT);
    assign rx.locked = (st_ff == mml_pkg::R_BITS);
    assign rx.done = done_ff;
    assign rx.err = err_ff;
    assign rx.bits = sr_ff;
    // =====================================================
    // bit sampler at the known reply bit period
    always_ff @(posedge ref_clk_in) begin // RL22
        if (!nrst_in) begin
            st_ff <= mml_pkg::R_OFF;
            prev_ff <= 1'b0;
            cnt_ff <= '0;
            nbit_ff <= '0;
            sr_ff <= '0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            prev_ff <= rx.line;
            cnt_ff <= mid_w | (rise_w & (st_ff == mml_pkg::R_HUNT)) ? '0 : cnt_ff + CW'(1);
            done_ff <= last_w & ~sync_bad_w;
            err_ff <= sync_bad_w | (rx.locked & ~mid_w & late_w & rx.en);
            if (mid_w) begin
                nbit_ff <= nbit_ff + 6'h01;
                sr_ff <= nbit_ff >= 6'h02 ? {sr_ff[mml_pkg::ACK_BITS-4:0], val_w} : sr_ff;
            end
            unique case (st_ff)
                mml_pkg::R_OFF: begin
                    st_ff <= rx.en ? mml_pkg::R_HUNT : mml_pkg::R_OFF;
                end
                mml_pkg::R_HUNT: begin
                    if (!rx.en) begin
                        st_ff <= mml_pkg::R_OFF;
                    end else if (rise_w) begin
                        st_ff <= mml_pkg::R_BITS;
                        nbit_ff <= 6'h01;
                    end
                end
                mml_pkg::R_BITS: begin
                    if (!rx.en || sync_bad_w || last_w || (late_w && !mid_w)) begin
                        st_ff <= mml_pkg::R_OFF;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** logic/mml_prog_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1: access code sent right after reset release
// RL2: link bit rate kept within 32-80 kbps
// RL3: bit period near 14.3 us at 70 kbps
// RL4: fixed period, receiver tolerates eleven percent drift
// RL5: two bit gap after volatile write
// RL6: two bit gap after second pulse
// RL7: two bit gap after read acknowledge
// RL8: reply expected within 150 us of read
// RL9: first pulse 40 us after write end
// RL10: supply nominal outside frames, restored immediately
// RL11: falling mid edge one, rising zero
// RL12: sync, direction, address, data, checksum, msb first
// RL13: read carries direction one, address, checksum
// RL14: write carries direction zero, upper six zero
// RL15: address top bit zero means eeprom
// RL16: reply fields ecc status and 24 data
// RL17: device replaces upper bits with check bits
// RL18: checksum x3+x+1 seeded 111, bad reply flagged
// RL19: only reads are answered, by device
// RL20: device locks out without timely access code
// RL21: device measures period from sync edges
// RL22: reply assumed at our own bit period
module mml_prog_ctrl #(
    parameter int RESP_MAX_CYC = mml_pkg::RESP_MAX_CYC,
    parameter int UNLOCK_CYC = mml_pkg::UNLOCK_CYC,
    parameter int PULSE_CYC = mml_pkg::PULSE_CYC,
    parameter int PULSE_GAP_CYC = mml_pkg::PULSE_GAP_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // command port
    input wire logic cmd_valid_in,
    input wire logic cmd_read_in,
    input wire logic [mml_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [mml_pkg::PAY_W-1:0] cmd_data_in,
    output logic cmd_ready_out,
    // results
    output logic wr_done_out,
    output logic rsp_valid_out,
    output logic rsp_err_out,
    output logic [1:0] rsp_ecc_out,
    output logic [mml_pkg::PAY_W-1:0] rsp_data_out,
    output logic unlocked_out,
    output logic unlock_late_out,
    // supply pin modulation
    output logic supply_manch_out,
    output logic supply_coded_out,
    // sensor output pin
    input wire logic sensor_output_pin_in,
    output logic sensor_pulse_out,
    output logic sensor_pulse_oe_n_out
);
    localparam int CW = mml_pkg::CNT_W;
    localparam int FW = mml_pkg::FRAME_W;
    localparam int BW = mml_pkg::BODY_W;
    localparam int DW = mml_pkg::DATA_W;
    mml_pkg::mml_state_t state_ff;
    mml_pkg::mml_state_t nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] unlock_cnt_ff;
    logic [CW-1:0] gap_lim_ff;
    logic [FW-1:0] shift_ff;
    logic [5:0] bits_left_ff;
    logic half_ff;
    logic manch_ff;
    logic coded_ff;
    logic pulse_ff;
    logic second_ff;
    logic op_read_ff;
    logic op_eeprom_ff;
    logic op_access_ff;
    logic pend_ff;
    logic late_ff;
    logic wr_done_ff;
    logic rsp_valid_ff;
    logic rsp_err_ff;
    logic [1:0] rsp_ecc_ff;
    logic [mml_pkg::PAY_W-1:0] rsp_data_ff;
    logic pin_meta_ff;
    logic pin_sync_ff;
    mml_rx_if rx_bus ();
    // =====================================================
    // frame assembly
    wire idle_w = (state_ff == mml_pkg::S_IDLE);
    wire take_w = idle_w & (pend_ff | cmd_valid_in);
    wire ld_read_w = ~pend_ff & cmd_read_in;
    wire [5:0] ld_addr_w = pend_ff ? mml_pkg::ACCESS_ADDR : cmd_addr_in; // RL1
    wire [DW-1:0] ld_data_w = pend_ff ? mml_pkg::ACCESS_DATA : {6'h00, cmd_data_in}; // RL14
    wire [BW-1:0] ld_body_w = ld_read_w ? {1'b1, ld_addr_w, 30'h00000000} // RL13
                                        : {1'b0, ld_addr_w, ld_data_w}; // RL14
    wire [2:0] ld_crc_w = mml_pkg::crc_msb(ld_body_w, ld_read_w ? mml_pkg::READ_BODY : BW); // RL18
    wire [FW-1:0] ld_frame_w = ld_read_w
        ? {2'b00, ld_body_w[BW-1:DW], ld_crc_w, 30'h00000000} // RL13
        : {2'b00, ld_body_w, ld_crc_w}; // RL12
    wire [5:0] ld_len_w = ld_read_w ? 6'(mml_pkg::READ_BITS) : 6'(FW);
    wire ld_eeprom_w = ~ld_read_w & ~ld_addr_w[mml_pkg::ADDR_SEL_BIT]; // RL15
    // =====================================================
    // timing decode
    wire [CW-1:0] lim_w =
        (state_ff == mml_pkg::S_TX) ? CW'(mml_pkg::HALF_CYC - 1) : // RL2 RL3
        (state_ff == mml_pkg::S_SETUP) ? CW'(mml_pkg::SETUP_CYC - 1) : // RL9
        (state_ff == mml_pkg::S_PULSE) ? CW'(PULSE_CYC - 1) :
        (state_ff == mml_pkg::S_PGAP) ? CW'(PULSE_GAP_CYC - 1) :
        (state_ff == mml_pkg::S_RESP) ? CW'(RESP_MAX_CYC + mml_pkg::BIT_CYC - 1) : // RL8
        gap_lim_ff;
    wire tick_w = (cnt_ff == lim_w);
    wire bit_end_w = (state_ff == mml_pkg::S_TX) & tick_w & half_ff;
    wire frame_end_w = bit_end_w & (bits_left_ff == 6'h01);
    wire resp_to_w = (state_ff == mml_pkg::S_RESP) & tick_w & ~rx_bus.locked; // RL8
    wire rx_fin_w = (state_ff == mml_pkg::S_RESP) & (rx_bus.done | rx_bus.err | resp_to_w);
    wire [2:0] rx_crc_w = mml_pkg::crc_msb({rx_bus.bits[DW+2:3], 7'h00}, DW); // RL18
    wire rx_ok_w = rx_bus.done & (rx_crc_w == rx_bus.bits[2:0]); // RL18
    wire leave_gap_w = (state_ff == mml_pkg::S_GAP) & tick_w;
    wire [CW-1:0] gap_sel_w = op_read_ff ? CW'(mml_pkg::GAP_CYC + mml_pkg::HALF_CYC) // RL7
                                         : CW'(mml_pkg::GAP_CYC); // RL5
    // =====================================================
    // sequence control
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mml_pkg::S_IDLE: begin
                if (take_w) begin
                    nxt_state = mml_pkg::S_TX;
                end
            end
            mml_pkg::S_TX: begin
                if (frame_end_w) begin
                    nxt_state = op_read_ff ? mml_pkg::S_RESP // RL19
                              : op_eeprom_ff ? mml_pkg::S_SETUP // RL9
                              : mml_pkg::S_GAP; // RL5
                end
            end
            mml_pkg::S_SETUP: begin
                if (tick_w) begin
                    nxt_state = mml_pkg::S_PULSE;
                end
            end
            mml_pkg::S_PULSE: begin
                if (tick_w) begin
                    nxt_state = second_ff ? mml_pkg::S_GAP : mml_pkg::S_PGAP; // RL6
                end
            end
            mml_pkg::S_PGAP: begin
                if (tick_w) begin
                    nxt_state = mml_pkg::S_PULSE;
                end
            end
            mml_pkg::S_RESP: begin
                if (rx_fin_w) begin
                    nxt_state = mml_pkg::S_GAP; // RL7
                end
            end
            mml_pkg::S_GAP: begin
                if (tick_w) begin
                    nxt_state = mml_pkg::S_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            state_ff <= mml_pkg::S_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state != state_ff) | tick_w ? '0 : cnt_ff + CW'(1);
        end
    end
    // =====================================================
    // operation flags
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            op_read_ff <= 1'b0;
            op_eeprom_ff <= 1'b0;
            op_access_ff <= 1'b0;
            pend_ff <= 1'b1;
            second_ff <= 1'b0;
            gap_lim_ff <= '0;
        end else begin
            if (take_w) begin
                op_read_ff <= ld_read_w;
                op_eeprom_ff <= ld_eeprom_w;
                op_access_ff <= pend_ff;
                pend_ff <= 1'b0; // RL1
                second_ff <= 1'b0;
            end
            if ((state_ff == mml_pkg::S_PULSE) && tick_w) begin
                second_ff <= 1'b1;
            end
            if (nxt_state == mml_pkg::S_GAP && state_ff != mml_pkg::S_GAP) begin
                gap_lim_ff <= gap_sel_w - CW'(1);
            end
        end
    end
    // =====================================================
    // manchester transmitter on the supply pin
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            shift_ff <= '0;
            bits_left_ff <= '0;
            half_ff <= 1'b0;
            manch_ff <= 1'b0;
            coded_ff <= 1'b0;
        end else if (take_w) begin
            shift_ff <= ld_frame_w;
            bits_left_ff <= ld_len_w;
            half_ff <= 1'b0;
            manch_ff <= 1'b1; // RL10
            coded_ff <= ld_frame_w[FW-1]; // RL11
        end else if ((state_ff == mml_pkg::S_TX) && tick_w) begin
            half_ff <= ~half_ff;
            if (!half_ff) begin
                coded_ff <= ~shift_ff[FW-1]; // RL11
            end else begin
                shift_ff <= {shift_ff[FW-2:0], 1'b0}; // RL12
                bits_left_ff <= bits_left_ff - 6'h01;
                coded_ff <= shift_ff[FW-2];
                manch_ff <= ~frame_end_w; // RL10
            end
        end
    end
    // =====================================================
    // programming strobes on the sensor output pin
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= (nxt_state == mml_pkg::S_PULSE); // RL9
        end
    end
    // =====================================================
    // reply reception
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= sensor_output_pin_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end
    assign rx_bus.en = (state_ff == mml_pkg::S_RESP);
    assign rx_bus.line = pin_sync_ff;
    mml_ack_rx #(
        .WIN_OPEN(mml_pkg::WIN_OPEN_CYC),
        .WIN_CLOSE(mml_pkg::WIN_CLOSE_CYC)
    ) u_ack_rx (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .rx(rx_bus.rx)
    );
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rsp_valid_ff <= 1'b0;
            rsp_err_ff <= 1'b0;
            rsp_ecc_ff <= 2'h0;
            rsp_data_ff <= '0;
        end else begin
            rsp_valid_ff <= rx_fin_w;
            if (rx_fin_w) begin
                rsp_err_ff <= ~rx_ok_w; // RL18
                rsp_ecc_ff <= rx_bus.bits[mml_pkg::ECC_HI+3:mml_pkg::ECC_LO+3]; // RL16
                rsp_data_ff <= rx_bus.bits[mml_pkg::PAY_W+2:3]; // RL16
            end
        end
    end
    // =====================================================
    // unlock deadline watch and write completion
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            unlock_cnt_ff <= '0;
            late_ff <= 1'b0;
            wr_done_ff <= 1'b0;
        end else begin
            if (unlock_cnt_ff != CW'(UNLOCK_CYC) && !(op_access_ff && frame_end_w)) begin
                unlock_cnt_ff <= unlock_cnt_ff + CW'(1);
            end
            if (op_access_ff && frame_end_w && unlock_cnt_ff == CW'(UNLOCK_CYC)) begin
                late_ff <= 1'b1; // RL1
            end
            wr_done_ff <= leave_gap_w & ~op_read_ff;
        end
    end
    // =====================================================
    // outputs
    assign cmd_ready_out = idle_w & ~pend_ff;
    assign wr_done_out = wr_done_ff;
    assign rsp_valid_out = rsp_valid_ff;
    assign rsp_err_out = rsp_err_ff;
    assign rsp_ecc_out = rsp_ecc_ff;
    assign rsp_data_out = rsp_data_ff;
    assign unlocked_out = ~pend_ff & ~(op_access_ff & ~idle_w) & ~late_ff;
    assign unlock_late_out = late_ff;
    assign supply_manch_out = manch_ff;
    assign supply_coded_out = coded_ff;
    assign sensor_pulse_out = pulse_ff;
    assign sensor_pulse_oe_n_out = ~pulse_ff;
endmodule
`default_nettype wire

// *** test/mml_prog_ctrl_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// port checker
module mml_prog_ctrl_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // observed ports
    input wire logic cmd_ready_out,
    input wire logic unlocked_out,
    input wire logic supply_manch_out,
    input wire logic supply_coded_out,
    input wire logic sensor_pulse_out,
    input wire logic sensor_pulse_oe_n_out
);
    logic coded_q_ff;
    logic [15:0] run_ff, idle_ff, since_ff, len_ff;
    wire logic coded_chg = supply_coded_out != coded_q_ff;
    wire logic link_busy = supply_manch_out || sensor_pulse_out;
    wire logic [15:0] nxt_run = !supply_manch_out ? 16'h0 : coded_chg ? 16'h1 : run_ff + 16'h1;
    wire logic [15:0] nxt_idle = link_busy ? 16'h0 : idle_ff + 16'(idle_ff != 16'hFFFF);
    wire logic [15:0] nxt_since = supply_manch_out ? 16'h0 : since_ff + 16'(since_ff != 16'hFFFF);
    always_ff @(posedge ref_clk_in) begin
        coded_q_ff <= supply_coded_out;
        run_ff <= nxt_run;
        len_ff <= supply_manch_out ? len_ff + 16'h1 : 16'h0;
        idle_ff <= nrst_in ? nxt_idle : 16'hFFFF;
        since_ff <= nrst_in ? nxt_since : 16'hFFFF;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_ready_idle_link: assert property (
        cmd_ready_out |-> !supply_manch_out && !sensor_pulse_out) else $error("ready while busy");
    a_pulse_out_frame: assert property (
        sensor_pulse_out |-> !supply_manch_out) else $error("pulse during frame");
    a_pulse_setup_time: assert property (
        $rose(sensor_pulse_out) |-> since_ff >= mml_pkg::SETUP_CYC) else $error("pulse too early");
    a_frame_gap_held: assert property (
        $rose(supply_manch_out) |-> idle_ff >= mml_pkg::GAP_CYC) else $error("gap too short");
    a_half_cell_edge: assert property (
        coded_chg && supply_manch_out && $past(supply_manch_out)
        |-> run_ff == mml_pkg::HALF_CYC || run_ff == mml_pkg::BIT_CYC) else $error("bad half cell");
    a_cell_bound_kept: assert property (
        supply_manch_out |-> run_ff <= mml_pkg::BIT_CYC) else $error("cell without edge");
    a_restore_at_end: assert property (
        $fell(supply_manch_out) |-> run_ff == mml_pkg::HALF_CYC) else $error("late restore");
    a_frame_length_ok: assert property (
        $fell(supply_manch_out) |-> len_ff == mml_pkg::FRAME_W * mml_pkg::BIT_CYC
        || len_ff == mml_pkg::READ_BITS * mml_pkg::BIT_CYC) else $error("bad frame length");
    a_oe_pulse_pair: assert property (
        sensor_pulse_oe_n_out == !sensor_pulse_out) else $error("enable not inverse");
    a_ready_after_unlock: assert property (
        cmd_ready_out |-> unlocked_out) else $error("ready while locked");
endmodule
`default_nettype wire

// *** test/mml_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// device model
module mml_dev_model (
    // clock and power-up
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // pins
    input wire logic supply_manch_in,
    input wire logic supply_coded_in,
    input wire logic sensor_pulse_in,
    input wire logic [15:0] delay_in,
    output logic dev_pin_out,
    // observations
    output int viol_out,
    output int pulses_out,
    output int bits_out,
    output logic [36:0] body_out
);
    logic lv[$];
    logic b[$];
    logic [23:0] mem [64];
    logic [5:0] rd_addr;
    logic in_frame, pul_q, open;
    int now, frame_end, quiet, per;
    event go_ack;
    function automatic logic [2:0] chk3(input logic q[$]);
        logic [2:0] c;
        logic fb;
        c = 3'h7;
        foreach (q[i]) begin
            fb = c[2] ^ q[i];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction
    task automatic decode();
        int m = 0;
        int e = 0;
        b.delete();
        for (int i = 1; i < lv.size(); i++) begin
            if (lv[i] != lv[i-1]) begin
                if (e == 0) m = i;
                if (e == 2) per = i - m;
                e++;
            end
        end
        for (int k = 0; per > 0 && m - per / 4 + k * per < lv.size(); k++) begin
            b.push_back(lv[m - per / 4 + k * per]);
        end
        bits_out = b.size();
        if (b.size() < 6) return;
        body_out = '0;
        for (int i = 2; i < b.size() - 3; i++) body_out = {body_out[35:0], b[i]};
        if (b[0] || b[1] || chk3(b[2:$-3]) != {b[$-2], b[$-1], b[$]}) begin
            viol_out++;
        end else if (b.size() == 42 && !body_out[36]) begin
            if (body_out[35:30] == 6'h24 && body_out[29:0] == 30'h27811F77 && now < 800000) begin
                open = 1'b1;
            end else if (open) begin
                mem[body_out[35:30]] = body_out[23:0];
            end
        end else if (b.size() == 12 && body_out[6] && open) begin
            rd_addr = body_out[5:0];
            -> go_ack;
        end
    endtask
    always @(posedge ref_clk_in) begin
        now++;
        if (!nrst_in) begin
            now = 0;
            open = 1'b0;
            in_frame = 1'b0;
            quiet = -1000000;
            per = mml_pkg::BIT_CYC;
        end else if (supply_manch_in) begin
            if (!in_frame && now - quiet < 2 * per) viol_out++;
            if (!in_frame) lv.delete();
            if (!in_frame) pulses_out = 0;
            in_frame = 1'b1;
            lv.push_back(supply_coded_in);
        end else if (in_frame) begin
            in_frame = 1'b0;
            frame_end = now;
            quiet = now;
            decode();
        end
        if (sensor_pulse_in && !pul_q && pulses_out == 0 && now - frame_end < 4000) viol_out++;
        if (sensor_pulse_in && !pul_q) pulses_out++;
        if (!sensor_pulse_in && pul_q) quiet = now;
        pul_q = sensor_pulse_in;
    end
    initial begin
        logic a[$];
        logic [29:0] w;
        logic [2:0] c;
        dev_pin_out = 1'b0;
        viol_out = 0;
        pulses_out = 0;
        pul_q = 1'b0;
        forever begin
            @(go_ack);
            repeat (delay_in) @(posedge ref_clk_in);
            w = {4'h9, 2'h0, mem[rd_addr]};
            a.delete();
            for (int i = 29; i >= 0; i--) a.push_back(w[i]);
            c = chk3(a);
            a = {1'b0, 1'b0, a, c[2], c[1], c[0]};
            foreach (a[i]) begin
                dev_pin_out <= a[i];
                repeat (per / 2) @(posedge ref_clk_in);
                dev_pin_out <= !a[i];
                repeat (per - per / 2) @(posedge ref_clk_in);
            end
            dev_pin_out <= 1'b0;
            quiet = now;
        end
    end
endmodule
`default_nettype wire

// *** test/test_manchester_programming_link.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_manchester_programming_link;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [5:0] cmd_addr = 6'h0;
    logic [23:0] cmd_data = 24'h0;
    logic [15:0] dly = 16'd2643;
    logic ready, wr_done, rsp_valid, rsp_err, unlocked, late, manch, coded, pulse, oe_n, dev_pin;
    logic [1:0] ecc;
    logic [23:0] rsp_data;
    logic [36:0] body;
    wire logic pin = !oe_n ? pulse : dev_pin;
    int viol, pulses, bits, mismatches, compares;
    int exp_mem [int];
    logic [5:0] a;
    logic [23:0] d;
    always #5 ref_clk_in = ~ref_clk_in;
    mml_prog_ctrl #(.RESP_MAX_CYC(3000), .UNLOCK_CYC(70000), .PULSE_CYC(50), .PULSE_GAP_CYC(50)) dut (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid),
        .cmd_read_in(cmd_read), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
        .cmd_ready_out(ready), .wr_done_out(wr_done), .rsp_valid_out(rsp_valid),
        .rsp_err_out(rsp_err), .rsp_ecc_out(ecc), .rsp_data_out(rsp_data),
        .unlocked_out(unlocked), .unlock_late_out(late), .supply_manch_out(manch),
        .supply_coded_out(coded), .sensor_output_pin_in(pin), .sensor_pulse_out(pulse),
        .sensor_pulse_oe_n_out(oe_n));
    mml_dev_model u_dev (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .supply_manch_in(manch),
        .supply_coded_in(coded), .sensor_pulse_in(pulse), .delay_in(dly), .dev_pin_out(dev_pin),
        .viol_out(viol), .pulses_out(pulses), .bits_out(bits), .body_out(body));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_on(input logic rdy);
        int n = 0;
        do begin
            @(negedge ref_clk_in);
            n++;
        end while ((rdy ? ready : wr_done | rsp_valid) !== 1'b1 && n < 200000);
        if (n >= 200000) mismatches++;
        if (n >= 200000) stop_test();
    endtask
    task automatic run_cmd(input logic rd, input logic [5:0] ad, input logic [23:0] da);
        @(posedge ref_clk_in);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr <= ad;
        cmd_data <= da;
        wait_on(1'b1);
        @(posedge ref_clk_in);
        cmd_valid <= 1'b0;
        wait_on(1'b0);
    endtask
    initial begin
        void'($urandom(49));
        repeat (10) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        wait_on(1'b1);
        check(body, {1'b0, 6'h24, 30'h27811F77});
        check(bits, 42);
        check(pulses, 0);
        check(unlocked, 1'b1);
        check(late, 1'b0);
        a = {1'b0, 5'($urandom)};
        d = 24'($urandom);
        run_cmd(1'b0, a, d);
        exp_mem[a] = d;
        check(wr_done, 1'b1);
        check(body, {1'b0, a, 6'h0, d});
        check(pulses, 2);
        dly <= 16'(2143 + $urandom % 1500);
        run_cmd(1'b1, a, 24'($urandom));
        check(body, {30'h0, 1'b1, a});
        check(bits, 12);
        check(rsp_valid, 1'b1);
        check(rsp_err, 1'b0);
        check(ecc, 2'h0);
        check(rsp_data, 24'(exp_mem[a]));
        wait_on(1'b1);
        check(viol, 0);
        stop_test();
    end
endmodule
bind mml_prog_ctrl mml_prog_ctrl_checker u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .cmd_ready_out(cmd_ready_out), .unlocked_out(unlocked_out),
    .supply_manch_out(supply_manch_out), .supply_coded_out(supply_coded_out),
    .sensor_pulse_out(sensor_pulse_out), .sensor_pulse_oe_n_out(sensor_pulse_oe_n_out));
`default_nettype wire
